// file: rtl/apc_map.svh
// Offsets, field positions, reset values and timing counts of the aux pin block.
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

`define APC_ADDR_W        12
`define APC_CFG_INDEX     6
`define APC_CFG_ADDR      12'h018
`define APC_CFG_W         24
`define APC_CFG_RESET     24'h00_0000
`define APC_CFG_WMASK     24'h05_EEEE
`define APC_LINK_EN_BIT   16
`define APC_WORD_FRM_BIT  18
`define APC_PIN_STRIDE    4
`define APC_MODE_LSB      2
`define APC_DRIVE_BIT     1
`define APC_SAMPLE_BIT    0
`define APC_LINK_PINS     3
`define APC_CLK_HZ        10000000
`define APC_FRAME_HZ      128000
`define APC_FRAME_CYC     (`APC_CLK_HZ / `APC_FRAME_HZ)
`define APC_DIV_W         7

`endif

// file: rtl/apc_pkg.sv
// Types shared by the aux pin block.
package apc_pkg;

  typedef enum logic [1:0] {
    APC_MODE_HIZ   = 2'b00,
    APC_MODE_IN    = 2'b01,
    APC_MODE_OUT   = 2'b10,
    APC_MODE_DRAIN = 2'b11
  } apc_mode_t;

  typedef enum logic [1:0] {
    APC_ST_IDLE,
    APC_ST_SHIFT,
    APC_ST_GAP
  } apc_link_st_t;

endpackage

// file: rtl/apc_link_tx.sv
// Secondary link master that streams one frame of words per frame tick.
`timescale 1ns/100ps
`default_nettype none
`include "apc_map.svh"

module apc_link_tx
  import apc_pkg::*;
#(
  parameter int WORD_W      = 8,
  parameter int FRAME_WORDS = 4
) (
  // Clock and reset.
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Control.
  input  wire logic                          i_enable,
  input  wire logic                          i_per_word,
  input  wire logic [FRAME_WORDS*WORD_W-1:0] i_data,
  // Link.
  output logic                               o_cs_n,
  output logic                               o_sclk,
  output logic                               o_mosi,
  output logic                               o_taken
);

  localparam int DW = FRAME_WORDS * WORD_W;
  localparam int BW = (WORD_W > 1) ? $clog2(WORD_W) : 1;
  localparam int FW = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1;
  localparam logic [`APC_DIV_W-1:0] DIV_LAST = `APC_DIV_W'(`APC_FRAME_CYC - 1);

  logic [`APC_DIV_W-1:0] div_r,   div_nxt;
  logic                  tick_r,  tick_nxt;
  apc_link_st_t          state_r, state_nxt;
  logic [DW-1:0]         sh_r,    sh_nxt;
  logic [BW-1:0]         bit_r,   bit_nxt;
  logic [FW-1:0]         word_r,  word_nxt;
  logic                  phase_r, phase_nxt;
  logic                  pw_r,    pw_nxt;
  logic                  cs_n_r,  cs_n_nxt;
  logic                  sclk_r,  sclk_nxt;
  logic                  mosi_r,  mosi_nxt;
  logic                  taken_r, taken_nxt;

  always_comb begin
    div_nxt   = (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
    tick_nxt  = (div_r == DIV_LAST); // R6
    state_nxt = state_r;
    sh_nxt    = sh_r;
    bit_nxt   = bit_r;
    word_nxt  = word_r;
    phase_nxt = phase_r;
    pw_nxt    = pw_r;
    cs_n_nxt  = cs_n_r;
    sclk_nxt  = sclk_r;
    mosi_nxt  = mosi_r;
    taken_nxt = 1'b0;
    case (state_r)
      APC_ST_IDLE: begin
        cs_n_nxt = 1'b1;
        sclk_nxt = 1'b0;
        if (i_enable && tick_r) begin
          state_nxt = APC_ST_SHIFT;
          sh_nxt    = i_data;
          mosi_nxt  = i_data[DW-1];
          bit_nxt   = '0;
          word_nxt  = '0;
          phase_nxt = 1'b0;
          pw_nxt    = i_per_word;
          cs_n_nxt  = 1'b0; // R11
          taken_nxt = 1'b1;
        end
      end
      APC_ST_SHIFT: begin
        phase_nxt = ~phase_r;
        sclk_nxt  = ~phase_r; // R11
        if (phase_r) begin
          sh_nxt   = {sh_r[DW-2:0], 1'b0};
          mosi_nxt = sh_r[DW-2];
          if (bit_r == BW'(WORD_W - 1)) begin
            bit_nxt = '0;
            if (word_r == FW'(FRAME_WORDS - 1)) begin
              state_nxt = APC_ST_IDLE;
              cs_n_nxt  = 1'b1;
            end else begin
              word_nxt  = word_r + 1'b1;
              state_nxt = APC_ST_GAP;
              cs_n_nxt  = pw_r; // R9
            end
          end else begin
            bit_nxt = bit_r + 1'b1;
          end
        end
      end
      APC_ST_GAP: begin
        state_nxt = APC_ST_SHIFT;
        cs_n_nxt  = 1'b0;
      end
      default: begin
        state_nxt = APC_ST_IDLE;
      end
    endcase
    if (!i_enable) begin
      state_nxt = APC_ST_IDLE;
      cs_n_nxt  = 1'b1;
      sclk_nxt  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r   <= '0;
      tick_r  <= 1'b0;
      state_r <= APC_ST_IDLE;
      sh_r    <= '0;
      bit_r   <= '0;
      word_r  <= '0;
      phase_r <= 1'b0;
      pw_r    <= 1'b0;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      mosi_r  <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      tick_r  <= tick_nxt;
      state_r <= state_nxt;
      sh_r    <= sh_nxt;
      bit_r   <= bit_nxt;
      word_r  <= word_nxt;
      phase_r <= phase_nxt;
      pw_r    <= pw_nxt;
      cs_n_r  <= cs_n_nxt;
      sclk_r  <= sclk_nxt;
      mosi_r  <= mosi_nxt;
      taken_r <= taken_nxt;
    end
  end

  assign o_cs_n  = cs_n_r;
  assign o_sclk  = sclk_r;
  assign o_mosi  = mosi_r;
  assign o_taken = taken_r;

  a_gap_select: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    state_r == APC_ST_GAP |-> cs_n_r == pw_r)
    else $error("chip select wrong between words");
  a_clock_framed: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    cs_n_r |-> !sclk_r)
    else $error("serial clock high outside chip select");
  a_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    tick_r |=> !tick_r [*8])
    else $error("frame ticks too close");
  c_word_framed: cover property (@(posedge i_clk) disable iff (i_rst)
    state_r == APC_ST_GAP && pw_r && cs_n_r);

endmodule // apc_link_tx
`default_nettype wire

// file: rtl/apc_top.sv
// Aux pin control block with APB configuration and secondary link takeover.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "apc_map.svh"

// Behaviour
// R1 - Mode code 00 floats, 01 input, 10 push-pull, 11 open drain; reset 00.
// R2 - Mode fields sit at bits 15:14, 11:10, 7:6, 3:2 for pins 3..0.
// R3 - Drive value bits 13, 9, 5, 1 set the driven level; reset low.
// R4 - Open drain pulls low for value 0 and floats for value 1.
// R5 - Read-only bits 12, 8, 4, 0 return the sampled level of input pins.
// R6 - Enable bit 16 streams frames at 128 kHz on pins 0..2; reset off.
// R7 - While the link is on, pins 0..2 ignore their own settings.
// R8 - Pin 3 always follows its own mode, value and sampled bit.
// R9 - Bit 18 clear keeps select low per frame; set frames each word.
// R10 - Software writes zero to reserved bits 23:19 and 17; they read zero.
// R11 - The link is master, driving clock, select and data outward.
module apc_top
  import apc_pkg::*;
#(
  parameter int NPINS       = 4,
  parameter int WORD_W      = 8,
  parameter int FRAME_WORDS = 4
) (
  // Clock and reset.
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // APB slave.
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [`APC_ADDR_W-1:0]        i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  output logic      [31:0]                   o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // Aux pins.
  input  wire logic [NPINS-1:0]              i_pin_in,
  output logic      [NPINS-1:0]              o_pin_out,
  output logic      [NPINS-1:0]              o_pin_oe,
  // Frame data for the secondary link.
  input  wire logic [FRAME_WORDS*WORD_W-1:0] i_frame_data,
  output logic                               o_frame_taken
);

  logic [`APC_CFG_W-1:0] cfg_r,     cfg_nxt;
  logic [31:0]           prdata_r,  prdata_nxt;
  logic                  pready_r,  pready_nxt;
  logic                  pslverr_r, pslverr_nxt;
  logic [NPINS-1:0]      sync1_r,   sync2_r;
  logic [NPINS-1:0]      pin_out_r, pin_out_nxt;
  logic [NPINS-1:0]      pin_oe_r,  pin_oe_nxt;
  logic [NPINS-1:0]      sampled;
  logic [`APC_CFG_W-1:0] rd_val;
  logic                  access;
  logic                  hit;
  logic                  wr_done;
  logic                  link_en;
  logic                  link_cs_n;
  logic                  link_sclk;
  logic                  link_mosi;
  logic [`APC_LINK_PINS-1:0] link_pins;

  assign link_en   = cfg_r[`APC_LINK_EN_BIT];
  assign link_pins = {link_mosi, link_sclk, link_cs_n};
  assign access    = i_psel && i_penable;
  assign hit       = (i_paddr == `APC_CFG_ADDR);
  assign wr_done   = access && pready_r && i_pwrite && hit;

  // The pins reach us from outside the clock domain, so they are resynced.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_pin_in;
      sync2_r <= sync1_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      apc_mode_t mode;
      logic      val;
      logic      own;
      logic      po;
      logic      pe;
      assign mode = apc_mode_t'(cfg_r[gi*`APC_PIN_STRIDE+`APC_MODE_LSB +: 2]);
      assign val  = cfg_r[gi*`APC_PIN_STRIDE+`APC_DRIVE_BIT];
      // Pin 3 is outside the link group and is never taken over.
      assign own  = link_en && (gi < `APC_LINK_PINS); // R7 R8
      always_comb begin
        po = 1'b0;
        pe = 1'b0;
        if (own) begin
          po = link_pins[gi % `APC_LINK_PINS]; // R6 R11
          pe = 1'b1;
        end else begin
          case (mode) // R1
            APC_MODE_OUT: begin
              po = val; // R3
              pe = 1'b1;
            end
            APC_MODE_DRAIN: begin
              po = 1'b0; // R4
              pe = ~val;
            end
            default: begin
              po = 1'b0;
              pe = 1'b0;
            end
          endcase
        end
      end
      assign pin_out_nxt[gi] = po;
      assign pin_oe_nxt[gi]  = pe;
      // A link pin reads zero, since its level belongs to the link.
      assign sampled[gi] = sync2_r[gi] && !own && (mode == APC_MODE_IN); // R5
    end
  endgenerate

  always_comb begin
    rd_val = cfg_r;
    for (int i = 0; i < NPINS; i++) begin
      rd_val[i*`APC_PIN_STRIDE+`APC_SAMPLE_BIT] = sampled[i]; // R5
    end
  end

  // One wait state lets read data and pready both come from flip-flops.
  always_comb begin
    cfg_nxt     = cfg_r;
    pready_nxt  = access && !pready_r;
    pslverr_nxt = access && !pready_r && !hit;
    prdata_nxt  = '0;
    if (access && !pready_r && !i_pwrite && hit) begin
      prdata_nxt = {{(32-`APC_CFG_W){1'b0}}, rd_val};
    end
    if (wr_done) begin
      // Reserved and read-only bits are masked; reserved bits read zero, read-only bits read the sampled level.
      cfg_nxt = i_pwdata[`APC_CFG_W-1:0] & `APC_CFG_WMASK; // R2 R10
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r     <= `APC_CFG_RESET;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else begin
      cfg_r     <= cfg_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  apc_link_tx #(
    .WORD_W      (WORD_W),
    .FRAME_WORDS (FRAME_WORDS)
  ) u_link (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_enable   (link_en),
    .i_per_word (cfg_r[`APC_WORD_FRM_BIT]),
    .i_data     (i_frame_data),
    .o_cs_n     (link_cs_n),
    .o_sclk     (link_sclk),
    .o_mosi     (link_mosi),
    .o_taken    (o_frame_taken)
  );

  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_pin_out = pin_out_r;
  assign o_pin_oe  = pin_oe_r;

  a_float_mode: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    cfg_r[15:14] == APC_MODE_HIZ || cfg_r[15:14] == APC_MODE_IN
    |=> !o_pin_oe[3])
    else $error("pin 3 driven while floating or input");
  a_push_pull: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    cfg_r[15:14] == APC_MODE_OUT
    |=> o_pin_oe[3] && o_pin_out[3] == $past(cfg_r[13]))
    else $error("pin 3 push-pull level wrong");
  a_open_drain: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    cfg_r[15:14] == APC_MODE_DRAIN
    |=> !o_pin_out[3] && o_pin_oe[3] == !$past(cfg_r[13]))
    else $error("pin 3 open drain wrong");
  a_field_write: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    wr_done |=> cfg_r[15:14] == $past(i_pwdata[15:14])
      && cfg_r[3:2] == $past(i_pwdata[3:2]))
    else $error("mode field not written");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    o_pready && !o_pslverr |-> o_prdata[31:19] == '0 && !o_prdata[17])
    else $error("reserved bits read nonzero");
  a_sample_gate: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    o_prdata[12] |-> $past(cfg_r[15:14]) == APC_MODE_IN)
    else $error("sampled bit set on non-input pin");
  a_link_takes: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    link_en |=> o_pin_oe[2:0] == 3'b111)
    else $error("link pins not driven");
  a_link_pins: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    link_en |=> o_pin_out[1] == $past(link_sclk)
      && o_pin_out[0] == $past(link_cs_n))
    else $error("link signals not on pins");
  a_pin3_own: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    link_en && cfg_r[15:14] == APC_MODE_HIZ |=> !o_pin_oe[3])
    else $error("pin 3 taken by link");
  a_link_frame: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    link_en && !o_frame_taken ##1 link_en [*2] |-> ##[1:100] o_frame_taken
    or ##[0:100] !link_en)
    else $error("no frame within one frame period");
  c_apb_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_done);
  c_drain_low: cover property (@(posedge i_clk) disable iff (i_rst)
    o_pin_oe[3] && !o_pin_out[3] && cfg_r[15:14] == APC_MODE_DRAIN);
  c_frame_sent: cover property (@(posedge i_clk) disable iff (i_rst)
    o_frame_taken ##[1:80] !link_cs_n);

endmodule // apc_top
`default_nettype wire

// file: verification/apc_pin_partner.sv
// External logic on the aux pins, with a receiver for the secondary link.
`timescale 1ns/100ps
`default_nettype none

module apc_pin_partner (
  // Clock and counter clear.
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  // Block side of the pins.
  input  wire logic [3:0]  i_out,
  input  wire logic [3:0]  i_oe,
  // Outside drivers.
  input  wire logic [3:0]  i_ext_oe,
  input  wire logic [3:0]  i_ext_val,
  // Resolved wire levels and link capture.
  output logic      [3:0]  o_wire,
  output logic      [31:0] o_rx_word,
  output logic      [7:0]  o_rx_bits,
  output logic      [7:0]  o_cs_rises
);
  logic prev_sclk;
  logic prev_cs;

  // A released pin floats up through the pull-up that open drain needs.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_wire[i] = i_oe[i] ? i_out[i] : (i_ext_oe[i] ? i_ext_val[i] : 1'b1);
    end
  end

  // Slave end of the link: pin 0 select, pin 1 clock, pin 2 data.
  always_ff @(posedge i_clk) begin
    prev_sclk <= o_wire[1];
    prev_cs   <= o_wire[0];
    if (i_clr) begin
      o_rx_word  <= 32'h0000_0000;
      o_rx_bits  <= 8'h00;
      o_cs_rises <= 8'h00;
    end else begin
      if (o_wire[1] && !prev_sclk && !o_wire[0]) begin
        o_rx_word <= {o_rx_word[30:0], o_wire[2]};
        o_rx_bits <= o_rx_bits + 8'h01;
      end
      if (o_wire[0] && !prev_cs) begin
        o_cs_rises <= o_cs_rises + 8'h01;
      end
    end
  end
endmodule // apc_pin_partner

`default_nettype wire

// file: verification/tb_apc_top.sv
// Self-checking bench for the aux pin block and its secondary link.
`timescale 1ns/100ps
`default_nettype none
`include "apc_map.svh"

module tb_apc_top;
  import apc_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [31:0] frame_data;
  logic        frame_taken;
  logic        clr;
  logic [3:0]  ext_oe;
  logic [3:0]  ext_val;
  logic [31:0] rx_word;
  logic [7:0]  rx_bits;
  logic [7:0]  cs_rises;
  logic [31:0] rdat;
  logic        rerr;
  int          err_total;
  int          n_checks;

  apc_top i_apc_top (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_frame_data(frame_data), .o_frame_taken(frame_taken)
  );

  apc_pin_partner i_apc_pin_partner (
    .i_clk(clk), .i_clr(clr), .i_out(pin_out), .i_oe(pin_oe),
    .i_ext_oe(ext_oe), .i_ext_val(ext_val), .o_wire(pin_in),
    .o_rx_word(rx_word), .o_rx_bits(rx_bits), .o_cs_rises(cs_rises)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits for pready without assuming a latency; the bound is a hang guard.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr32(input logic [31:0] d);
    apb(1'b1, `APC_CFG_ADDR, d, rdat, rerr);
  endtask

  task automatic rdchk(input logic [31:0] e);
    apb(1'b0, `APC_CFG_ADDR, 32'h0000_0000, rdat, rerr);
    chk(rdat, e);
  endtask

  task automatic t_reset;
    chk(32'({pin_oe, pin_out}), 32'h0000_0000);
    rdchk(32'h0000_0000);
  endtask

  task automatic t_modes;
    logic [31:0] v;
    logic [3:0]  eoe;
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 4; m++) begin
        for (int d = 0; d < 2; d++) begin
          v = 32'h0000_0000;
          v[4*p+2 +: 2] = m[1:0];
          v[4*p+1] = d[0];
          wr32(v);
          repeat (2) @(posedge clk);
          eoe = 4'h0;
          eoe[p] = (m[1:0] == APC_MODE_OUT) || (m == 3 && d == 0);
          chk(32'(pin_oe), 32'(eoe));
          if (m[1:0] == APC_MODE_OUT) chk(32'(pin_out[p]), 32'(d[0]));
          if (m[1:0] == APC_MODE_DRAIN) chk(32'(pin_in[p]), 32'(d[0]));
          // An undriven input pin sits at its pull-up, so it samples high.
          v[4*p] = (m == 1);
          rdchk(v);
        end
      end
    end
  endtask

  task automatic t_input;
    ext_oe  <= 4'hF;
    ext_val <= 4'hA;
    wr32(32'h0000_4444);
    repeat (4) @(posedge clk);
    rdchk(32'h0000_5454);
    ext_val <= 4'h5;
    repeat (4) @(posedge clk);
    rdchk(32'h0000_4545);
    wr32(32'h0000_EEEE);
    rdchk(32'h0000_EEEE);
    ext_oe <= 4'h0;
  endtask

  // Unmapped access is refused and leaves the register untouched.
  task automatic t_refused;
    apb(1'b1, 12'h01C, 32'h0000_4000, rdat, rerr);
    chk(32'(rerr), 32'h0000_0001);
    apb(1'b0, 12'h01C, 32'h0000_0000, rdat, rerr);
    chk({rdat[30:0], rerr}, 32'h0000_0001);
    rdchk(32'h0000_EEEE);
    // Reserved bits stay zero on write; read-only bits are written as ones.
    wr32(32'h0005_FFFF);
    rdchk({8'h00, `APC_CFG_WMASK});
    wr32(32'h0000_0000);
  endtask

  task automatic t_link(input logic pw);
    int          n;
    logic [31:0] v;
    v = 32'h0001_AAAA | (32'(pw) << 18);
    wr32(v);
    rdchk(v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (frame_taken !== 1'b1 && n < 200);
    if (n >= 200) err_total++;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (71) @(posedge clk);
    chk(rx_word, frame_data);
    chk(32'(rx_bits), 32'h0000_0020);
    chk(32'(cs_rises), pw ? 32'h0000_0004 : 32'h0000_0001);
    chk(32'({pin_oe[3], pin_out[3]}), 32'h0000_0003);
    chk(32'(pin_oe[2:0]), 32'h0000_0007);
    n = 72;
    do begin
      @(posedge clk);
      n++;
    end while (frame_taken !== 1'b1 && n < 200);
    chk(n, `APC_FRAME_CYC);
    wr32(32'h0000_AAAA);
    repeat (2) @(posedge clk);
    chk(32'({pin_oe, pin_out}), 32'h0000_00FF);
  endtask

  initial begin
    #2000000;
    err_total++;
    conclude();
  end

  initial begin
    err_total  = 0;
    n_checks   = 0;
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    frame_data = 32'hA53C_0F81;
    clr        = 1'b1;
    ext_oe     = 4'h0;
    ext_val    = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    t_reset();
    t_modes();
    t_input();
    t_refused();
    t_link(1'b0);
    t_link(1'b1);
    conclude();
  end
endmodule // tb_apc_top

`default_nettype wire
